//--- ppi_top.sv
/*
 pcm port pin block: two serial pcm ports on the bit clock, law and
 format pins, reset/standby pin, microport pin roles, avalon registers.
 assumes the bus drives strobes and data synchronous to the bit clock.
*/
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module ppi_top
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic BIT_CLOCK_INPUT,
    input wire logic FRAME_ALIGN_INPUT,
    input wire logic LINE_PORT_STROBE,
    input wire logic MIC_PORT_STROBE,
    input wire logic LINE_PORT_MODE_PIN,
    input wire logic MIC_PORT_MODE_PIN,
    input wire logic RECV_IN,
    input wire logic SEND_IN,
    output logic SEND_OUT,
    output logic RECV_OUT,
    input wire logic LAW_SEL,
    input wire logic CODE_FMT_SEL,
    input wire logic RESET_N,
    input wire logic UP_SEL_N,
    input wire logic UP_CLK,
    input wire logic MICROPORT_RECEIVE_LINE,
    input wire logic MICROPORT_BIDIR_LINE_I,
    output logic MICROPORT_BIDIR_LINE_O,
    output logic MICROPORT_BIDIR_LINE_OE
);
    import ppi_pkg::*;

    // master clock side state
    logic [SY_W-1:0] sy1_r, sy2_r, sy3_r, pin_r;
    logic [4:0] ctrl_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [15:0] line_smp_r, mic_smp_r;
    logic [15:0] txh_r [2];
    logic [1:0] txt_r;
    ppi_up_e up_st_r, up_st_nxt;
    logic [2:0] up_bit_r;
    logic [7:0] up_sh_r, up_byte_r, up_tx_r;
    logic up_o_r;
    // link clock side state
    logic [LK_W-1:0] lk1_r, lk2_r, lk3_r, lkp_r;
    logic [9:0] fcnt_r;
    logic [10:0] low_r;
    logic lk_strobed_r;
    logic [1:0] lk_tgl;
    logic [15:0] hold_w [2];
    logic [1:0] out_w;

    // pins and link signals entering the master clock domain
    wire [SY_W-1:0] sy_in = {lk_tgl, lk_strobed_r,
        MICROPORT_BIDIR_LINE_I, MICROPORT_RECEIVE_LINE, UP_CLK,
        UP_SEL_N, RESET_N, CODE_FMT_SEL, LAW_SEL};
    // a change counts only once the last two stages agree
    wire [SY_W-1:0] agree = ~(sy2_r ^ sy3_r);
    wire [SY_W-1:0] pin_nxt = (agree & sy3_r) | (~agree & pin_r);
    wire [SY_W-1:0] pin_chg = {SY_W{CE}} & (pin_nxt ^ pin_r);
    wire law_f = pin_r[SY_LAW];
    wire fmt_f = pin_r[SY_FMT];
    wire standby = ~pin_r[SY_RSTN];
    wire sel_f = pin_r[SY_SEL];
    wire strobed_f = pin_r[SY_STRB];
    wire [1:0] rx_evt = pin_chg[SY_TGL+1:SY_TGL];
    wire uclk_rise = pin_chg[SY_UCLK] & pin_nxt[SY_UCLK];
    wire uclk_fall = pin_chg[SY_UCLK] & ~pin_nxt[SY_UCLK];
    wire lin = ctrl_r[CB_LIN];
    wire shared = ctrl_r[CB_SHR];

    // companded code mask: law picks the table, format enables it
    wire [7:0] mask = fmt_f ? (law_f ? MASK_A : MASK_MU) : MASK_NONE;

    // path shaping; echo and gain stages are transparent here, mute
    // substitutes the quiet code of the active law and format
    function automatic logic [15:0] shape(input logic [15:0] s,
        input logic mute, input logic ln, input logic [7:0] m);
        logic [7:0] c;
        c = mute ? QUIET_SM : (s[7:0] ^ m);
        if (ln)
            shape = mute ? QUIET_LIN : s;
        else
            shape = {c ^ m, 8'h00};
    endfunction : shape

    // three-stage synchroniser with agreement filter
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            sy1_r <= SY_RST;
            sy2_r <= SY_RST;
            sy3_r <= SY_RST;
            pin_r <= SY_RST;
        end
        else if (CE)
        begin
            sy1_r <= sy_in;
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            pin_r <= pin_nxt;
        end
    end

    // avalon slave: one wait state, write lands on the release edge
    wire req = AVS_READ | AVS_WRITE;
    wire take = req & ~ack_r;
    assign AVS_WAITREQUEST = take;
    wire wr_ctrl = AVS_WRITE & ack_r & AVS_BYTEENABLE[0]
        & (AVS_ADDRESS == OFS_CTRL);
    wire [31:0] stat_w = {28'h0000000, fmt_f, law_f, standby, strobed_f};
    // unmapped offsets read as zero and ignore writes
    wire [31:0] rd_mux =
        (AVS_ADDRESS == OFS_CTRL) ? {27'h0000000, ctrl_r} :
        (AVS_ADDRESS == OFS_STAT) ? stat_w :
        (AVS_ADDRESS == OFS_LINE) ? {16'h0000, line_smp_r} :
        (AVS_ADDRESS == OFS_MIC) ? {16'h0000, mic_smp_r} :
        (AVS_ADDRESS == OFS_UP) ? {24'h000000, up_byte_r} : 32'h00000000;
    assign AVS_READDATA = rdata_r;

    // bus handshake and control register; standby clears the control register
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
            ctrl_r <= CTRL_RST;
        end
        else if (CE)
        begin
            ack_r <= take;
            if (take)
                rdata_r <= rd_mux;
            if (standby)
                ctrl_r <= CTRL_RST;
            else if (wr_ctrl)
                ctrl_r <= AVS_WRITEDATA[4:0];
        end
    end

    // sample exchange: line input feeds rx-out, mic input feeds send-out
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            line_smp_r <= 16'h0000;
            mic_smp_r <= 16'h0000;
            txh_r[0] <= 16'h0000;
            txh_r[1] <= 16'h0000;
            txt_r <= 2'h0;
        end
        else if (CE)
        begin
            if (standby)
            begin
                // held in reset while the pin is low
                line_smp_r <= 16'h0000;
                mic_smp_r <= 16'h0000;
                txh_r[0] <= 16'h0000;
                txh_r[1] <= 16'h0000;
            end
            else
            begin
                if (rx_evt[0])
                begin
                    // gain path toward the speaker
                    line_smp_r <= hold_w[0];
                    txh_r[1] <= shape(hold_w[0], ctrl_r[CB_MUTR], lin,
                        mask);
                    txt_r[1] <= ~txt_r[1];
                end
                if (rx_evt[1])
                begin
                    // echo-cancelled path toward the line
                    mic_smp_r <= hold_w[1];
                    txh_r[0] <= shape(hold_w[1], ctrl_r[CB_MUTS], lin,
                        mask);
                    txt_r[0] <= ~txt_r[0];
                end
            end
        end
    end

    // microport pin roles; the byte protocol above them is minimal
    wire urx = shared ? pin_r[SY_UBI] : pin_r[SY_URX];
    wire up_drv = (up_st_r == UP_SEND)
        | ((up_st_r == UP_RECV) & ~shared);
    assign MICROPORT_BIDIR_LINE_OE = up_drv & ~sel_f;
    assign MICROPORT_BIDIR_LINE_O = up_o_r;

    // microport next state
    always_comb
    begin
        up_st_nxt = up_st_r;
        unique case (up_st_r)
            UP_IDLE:
                if (!sel_f && !standby)
                    up_st_nxt = UP_RECV;
            UP_RECV:
                if (sel_f || standby)
                    up_st_nxt = UP_IDLE;
                else if (uclk_rise && up_bit_r == UP_LAST && shared)
                    up_st_nxt = UP_SEND;
            UP_SEND:
                if (sel_f || standby)
                    up_st_nxt = UP_IDLE;
            default:
                up_st_nxt = UP_IDLE;
        endcase
    end

    // microport shifting: in on rising clock, out on falling clock
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            up_st_r <= UP_IDLE;
            up_bit_r <= 3'h0;
            up_sh_r <= 8'h00;
            up_byte_r <= 8'h00;
            up_tx_r <= 8'h00;
            up_o_r <= 1'b0;
        end
        else if (CE)
        begin
            up_st_r <= up_st_nxt;
            if (up_st_r == UP_IDLE)
            begin
                // status byte waits for the next selection
                up_bit_r <= 3'h0;
                up_tx_r <= stat_w[7:0];
                up_o_r <= 1'b0;
            end
            else
            begin
                if (uclk_rise && up_st_r == UP_RECV)
                begin
                    up_sh_r <= {up_sh_r[6:0], urx};
                    up_bit_r <= up_bit_r + 3'h1;
                    if (up_bit_r == UP_LAST)
                        up_byte_r <= {up_sh_r[6:0], urx};
                end
                if (uclk_fall && up_drv)
                begin
                    up_o_r <= up_tx_r[7];
                    up_tx_r <= {up_tx_r[6:0], 1'b0};
                end
            end
        end
    end

    // control levels and sample toggles entering the link domain
    wire [LK_W-1:0] lk_in = {txt_r, standby, ctrl_r[CB_GCI], lin};
    wire [LK_W-1:0] lk_ag = ~(lk2_r ^ lk3_r);
    wire [LK_W-1:0] lkp_nxt = (lk_ag & lk3_r) | (~lk_ag & lkp_r);
    wire [1:0] lk_evt = lkp_nxt[LK_TGL+1:LK_TGL] ^ lkp_r[LK_TGL+1:LK_TGL];
    wire lk_lin = lkp_r[LK_LIN];
    wire lk_gci = lkp_r[LK_GCI];
    wire lk_stby = lkp_r[LK_STBY];
    wire [4:0] len = lk_lin ? LEN_LIN : LEN_COMP;

    // frame pulse polarity follows the framed or gci choice
    wire fa_act = lk_gci ? FRAME_ALIGN_INPUT : ~FRAME_ALIGN_INPUT;
    wire [10:0] low_nxt = FRAME_ALIGN_INPUT ? 11'h000 :
        ((low_r == STRB_DET) ? low_r : low_r + 11'h001);

    // link synchroniser, frame bit counter and strobed-mode detect;
    // the bit clock must keep running between strobes, since the sample
    // toggles need edges outside a word to cross into this domain
    always_ff @(posedge BIT_CLOCK_INPUT or posedge RST)
    begin
        if (RST)
        begin
            lk1_r <= LK_RST;
            lk2_r <= LK_RST;
            lk3_r <= LK_RST;
            lkp_r <= LK_RST;
            fcnt_r <= 10'h000;
            low_r <= 11'h000;
            lk_strobed_r <= 1'b0;
        end
        else
        begin
            lk1_r <= lk_in;
            lk2_r <= lk1_r;
            lk3_r <= lk2_r;
            lkp_r <= lkp_nxt;
            fcnt_r <= fa_act ? 10'h000 : fcnt_r + 10'h001;
            low_r <= low_nxt;
            // a grounded frame pin longer than any frame means strobes
            lk_strobed_r <= (low_nxt == STRB_DET);
        end
    end

    // per-port serial engines; port 0 is line in / send out, port 1
    // is mic in / rx out
    wire [1:0] strb_w = {MIC_PORT_STROBE, LINE_PORT_STROBE};
    wire [1:0] mode_w = {MIC_PORT_MODE_PIN, LINE_PORT_MODE_PIN};
    wire [1:0] in_w = {SEND_IN, RECV_IN};
    assign SEND_OUT = out_w[0];
    assign RECV_OUT = out_w[1];

    for (genvar k = 0; k < 2; k++)
    begin : g_port
        logic [4:0] cnt_r;
        logic [15:0] rsh_r, tsh_r, txb_r, hold_r;
        logic out_r, tgl_r;
        // strobe and mode pin choose a byte timeslot in framed modes
        wire [9:0] start = {5'h00, mode_w[k], strb_w[k], 3'h0};
        wire [9:0] ofs = fcnt_r - start;
        wire in_slot = (fcnt_r >= start) && (ofs < {5'h00, len});
        wire act = ~lk_stby & (lk_strobed_r ? strb_w[k] : in_slot);
        wire last = (cnt_r == len - 5'h01);
        wire [15:0] rnew = {rsh_r[14:0], in_w[k]};
        assign lk_tgl[k] = tgl_r;
        assign hold_w[k] = hold_r;
        assign out_w[k] = out_r;

        // one bit in and one bit out per bit period of the word
        always_ff @(posedge BIT_CLOCK_INPUT or posedge RST)
        begin
            if (RST)
            begin
                cnt_r <= 5'h00;
                rsh_r <= 16'h0000;
                tsh_r <= 16'h0000;
                txb_r <= 16'h0000;
                hold_r <= 16'h0000;
                out_r <= 1'b0;
                tgl_r <= 1'b0;
            end
            else
            begin
                if (lk_evt[k])
                    txb_r <= txh_r[k]; // stable since the toggle
                if (act)
                begin
                    rsh_r <= rnew;
                    tsh_r <= (cnt_r == 5'h00) ? {txb_r[14:0], 1'b0} :
                        {tsh_r[14:0], 1'b0};
                    out_r <= (cnt_r == 5'h00) ? txb_r[15] : tsh_r[15];
                    cnt_r <= last ? 5'h00 : cnt_r + 5'h01;
                    if (last)
                    begin
                        // hold stays put for a whole word while read
                        hold_r <= lk_lin ? rnew : {8'h00, rnew[7:0]};
                        tgl_r <= ~tgl_r;
                    end
                end
                else
                begin
                    cnt_r <= 5'h00;
                    out_r <= 1'b0;
                end
            end
        end

        a_strobe_idle: assert property (@(posedge BIT_CLOCK_INPUT)
            disable iff (RST) (lk_strobed_r && !strb_w[k])
            |=> !out_r)
            else $error("output active without strobe");
        a_word_done: assert property (@(posedge BIT_CLOCK_INPUT)
            disable iff (RST) (act && last) |=> $changed(tgl_r))
            else $error("word end not signalled");
    end

    a_mu_quiet: assert property (@(posedge MCLK) disable iff (RST)
        (CE && rx_evt[1] && !standby && ctrl_r[CB_MUTS] && !lin
        && fmt_f && !law_f) |=> txh_r[0][15:8] == 8'hFF)
        else $error("mu-law quiet code wrong");
    a_a_quiet: assert property (@(posedge MCLK) disable iff (RST)
        (CE && rx_evt[0] && !standby && ctrl_r[CB_MUTR] && !lin
        && fmt_f && law_f) |=> txh_r[1][15:8] == 8'hD5)
        else $error("a-law quiet code wrong");
    a_standby_clr: assert property (@(posedge MCLK) disable iff (RST)
        (CE && standby) |=> (ctrl_r == CTRL_RST) && (txh_r[0] == 16'h0000))
        else $error("standby did not clear state");
    a_sel_idle: assert property (@(posedge MCLK) disable iff (RST)
        sel_f |-> !MICROPORT_BIDIR_LINE_OE)
        else $error("bidir driven while deselected");
    a_split_drv: assert property (@(posedge MCLK) disable iff (RST)
        (up_st_r == UP_RECV && !shared && !sel_f)
        |-> MICROPORT_BIDIR_LINE_OE)
        else $error("split variant not driving");
    a_shared_rx: assert property (@(posedge MCLK) disable iff (RST)
        (up_st_r == UP_RECV && shared) |-> !MICROPORT_BIDIR_LINE_OE)
        else $error("shared variant drove while receiving");
    a_frame_zero: assert property (@(posedge BIT_CLOCK_INPUT)
        disable iff (RST) (lk_gci && FRAME_ALIGN_INPUT)
        |=> fcnt_r == 10'h000)
        else $error("gci pulse did not align frame");
    a_strb_enter: assert property (@(posedge BIT_CLOCK_INPUT)
        disable iff (RST) (low_r == STRB_DET && !FRAME_ALIGN_INPUT)
        |=> lk_strobed_r)
        else $error("strobed mode not entered");
endmodule : ppi_top

//--- ppi_pkg.sv
/*
 constants, field positions and state codes for the pcm port pin block.
 assumes a 32-bit avalon-mm slave on MCLK and a bit clock from the bus.
*/
package ppi_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STAT = 5'h04;
    localparam logic [4:0] OFS_LINE = 5'h08;
    localparam logic [4:0] OFS_MIC = 5'h0C;
    localparam logic [4:0] OFS_UP = 5'h10;
    // control fields and reset value
    localparam int CB_GCI = 0;
    localparam int CB_LIN = 1;
    localparam int CB_SHR = 2;
    localparam int CB_MUTS = 3;
    localparam int CB_MUTR = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;
    // code masks and quiet codes
    localparam logic [7:0] MASK_MU = 8'h7F;
    localparam logic [7:0] MASK_A = 8'h55;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] QUIET_SM = 8'h80;
    localparam logic [15:0] QUIET_LIN = 16'h0000;
    // word lengths in bit periods
    localparam logic [4:0] LEN_COMP = 5'h08;
    localparam logic [4:0] LEN_LIN = 5'h10;
    // low bit periods on the frame pin before strobed mode
    localparam logic [10:0] STRB_DET = 11'h400;
    // last bit index of a microport byte
    localparam logic [2:0] UP_LAST = 3'h7;
    // positions in the master-clock synchroniser
    localparam int SY_LAW = 0;
    localparam int SY_FMT = 1;
    localparam int SY_RSTN = 2;
    localparam int SY_SEL = 3;
    localparam int SY_UCLK = 4;
    localparam int SY_URX = 5;
    localparam int SY_UBI = 6;
    localparam int SY_STRB = 7;
    localparam int SY_TGL = 8;
    localparam int SY_W = 10;
    localparam logic [9:0] SY_RST = 10'h008;
    // positions in the link-clock synchroniser
    localparam int LK_LIN = 0;
    localparam int LK_GCI = 1;
    localparam int LK_STBY = 2;
    localparam int LK_TGL = 3;
    localparam int LK_W = 5;
    localparam logic [4:0] LK_RST = 5'h04;
    // microport states
    typedef enum logic [1:0] {
        UP_IDLE = 2'b00,
        UP_RECV = 2'b01,
        UP_SEND = 2'b10
    } ppi_up_e;
endpackage : ppi_pkg

//--- ppi_pcm_bus.sv
/*
 model of the pcm bus and codec beside the pcm port pins.
 assumes strobed operation: frame pin grounded, mode pins low.
*/
`timescale 1ns/1ps
module ppi_pcm_bus
(
    output logic bclk,
    output logic frame_pin,
    output logic line_stb,
    output logic mic_stb,
    output logic line_mode,
    output logic mic_mode,
    output logic line_data,
    output logic mic_data,
    input wire logic send_out,
    input wire logic recv_out
);
    // free running bit clock, phase unrelated to the master clock
    initial
    begin
        bclk = 1'b0;
        #13;
        forever #40 bclk = ~bclk;
    end
    // idle pin levels; grounded frame pin picks strobed mode
    initial
    begin
        frame_pin = 1'b0;
        line_mode = 1'b0;
        mic_mode = 1'b0;
        line_stb = 1'b0;
        mic_stb = 1'b0;
        line_data = 1'b0;
        mic_data = 1'b0;
    end
    // one 8-bit word on both ports; outputs caught one bit late
    task automatic frame(input logic [7:0] lb, input logic [7:0] mb,
        output logic [7:0] so, output logic [7:0] ro);
        so = 8'h00;
        ro = 8'h00;
        // idle bit periods first, so that the word shaped from the last
        // one has crossed into the link domain before this one starts
        repeat (6) @(posedge bclk);
        for (int i = 0; i < 11; i++)
        begin
            @(posedge bclk);
            // reads the level launched at the edge before: bits at 2..9
            if (i >= 2 && i < 10)
            begin
                so = {so[6:0], send_out};
                ro = {ro[6:0], recv_out};
            end
            // strobes change with the bit clock, eight bits wide
            line_stb <= (i < 8);
            mic_stb <= (i < 8);
            // after the word the lines stop showing the last bit
            line_data <= (i < 8) ? lb[3'h7 - i[2:0]] : ~line_data;
            mic_data <= (i < 8) ? mb[3'h7 - i[2:0]] : ~mic_data;
        end
    endtask : frame
endmodule : ppi_pcm_bus

//--- pcm_port_pin_interface_test.sv
/*
 self-checking bench for the pcm port pin block.
 assumes ppi_top, ppi_pkg and the bus model ppi_pcm_bus.
*/
`timescale 1ns/1ps
module pcm_port_pin_interface_test;
    import ppi_pkg::*;
    logic mclk, rst, avs_read, avs_write, law, fmt, rst_n, sel_n, uclk;
    logic urx, host_d, avs_wait, bclk, frame_pin, line_stb, mic_stb;
    logic line_mode, mic_mode, recv_in, send_in, send_out, recv_out;
    logic bd_o, bd_oe;
    logic [3:0] avs_be;
    logic [4:0] avs_addr;
    logic [31:0] avs_wdata, avs_rdata, q;
    logic [7:0] so, ro, qt;
    int err_count, num_checks;
    // microport data wire: the device wins while it drives
    wire logic bd_line = bd_oe ? bd_o : host_d;
    // master clock, 4 ns
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    ppi_top dut_u (.MCLK(mclk), .RST(rst), .CE(1'b1),
        .AVS_ADDRESS(avs_addr), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_wdata),
        .AVS_BYTEENABLE(avs_be), .AVS_READDATA(avs_rdata),
        .AVS_WAITREQUEST(avs_wait), .BIT_CLOCK_INPUT(bclk),
        .FRAME_ALIGN_INPUT(frame_pin), .LINE_PORT_STROBE(line_stb),
        .MIC_PORT_STROBE(mic_stb), .LINE_PORT_MODE_PIN(line_mode),
        .MIC_PORT_MODE_PIN(mic_mode), .RECV_IN(recv_in),
        .SEND_IN(send_in), .SEND_OUT(send_out), .RECV_OUT(recv_out),
        .LAW_SEL(law), .CODE_FMT_SEL(fmt), .RESET_N(rst_n),
        .UP_SEL_N(sel_n), .UP_CLK(uclk), .MICROPORT_RECEIVE_LINE(urx),
        .MICROPORT_BIDIR_LINE_I(bd_line), .MICROPORT_BIDIR_LINE_O(bd_o),
        .MICROPORT_BIDIR_LINE_OE(bd_oe));
    ppi_pcm_bus bus_u (.bclk(bclk), .frame_pin(frame_pin),
        .line_stb(line_stb), .mic_stb(mic_stb), .line_mode(line_mode),
        .mic_mode(mic_mode), .line_data(recv_in), .mic_data(send_in),
        .send_out(send_out), .recv_out(recv_out));
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wait_m(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_m
    // one bus cycle; holds until waitrequest is seen low
    task automatic av_xfer(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        avs_addr <= a;
        avs_wdata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_wait !== 1'b0 && n < 20);
        q = avs_rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (avs_wait !== 1'b0)
        begin
            err_count++;
            $display("BAD %0t bus answer never came", $time);
            stop_test();
        end
        @(posedge mclk);
    endtask : av_xfer
    // reset values, unmapped place, write without its byte lane
    task automatic t_reset();
        av_xfer(1'b0, OFS_CTRL, 32'h0);
        check(q, {27'h0, CTRL_RST}, "ctrl reset");
        av_xfer(1'b0, OFS_STAT, 32'h0);
        check(q, 32'h0, "status reset");
        av_xfer(1'b1, 5'h14, 32'hFFFFFFFF);
        av_xfer(1'b0, 5'h14, 32'h0);
        check(q, 32'h0, "unmapped read");
        avs_be <= 4'hE;
        av_xfer(1'b1, OFS_CTRL, 32'h1F);
        avs_be <= 4'hF;
        av_xfer(1'b0, OFS_CTRL, 32'h0);
        check(q, 32'h0, "ctrl lane 0 off");
    endtask : t_reset
    // grounded frame pin turns strobed mode on after 1024 bit clocks
    task automatic t_strobed();
        repeat (1100) @(posedge bclk);
        wait_m(1);
        av_xfer(1'b0, OFS_STAT, 32'h0);
        check(q, 32'h1, "strobed flag");
    endtask : t_strobed
    // law and format pins seen in status for every setting
    task automatic t_pins();
        for (int k = 0; k < 4; k++)
        begin
            law <= k[0];
            fmt <= k[1];
            wait_m(20);
            av_xfer(1'b0, OFS_STAT, 32'h0);
            check(q, {28'h0, k[1], k[0], 2'b01}, "law format");
        end
    endtask : t_pins
    // samples land in registers and pass through on the next word
    task automatic t_pass();
        law <= 1'b0;
        fmt <= 1'b0;
        wait_m(20);
        bus_u.frame(8'hA7, 8'h5C, so, ro);
        bus_u.frame(8'hA7, 8'h5C, so, ro);
        wait_m(20);
        av_xfer(1'b0, OFS_LINE, 32'h0);
        check(q, 32'hA7, "line sample");
        av_xfer(1'b0, OFS_MIC, 32'h0);
        check(q, 32'h5C, "mic sample");
        check(so, 8'h5C, "send out word");
        check(ro, 8'hA7, "recv out word");
        check({send_out, recv_out}, 2'b00, "idle outputs");
    endtask : t_pass
    // muted words carry the quiet code of each law and format
    task automatic t_mute();
        av_xfer(1'b1, OFS_CTRL, 32'h18);
        for (int k = 0; k < 4; k++)
        begin
            law <= k[0];
            fmt <= k[1];
            wait_m(20);
            qt = k[1] ? (k[0] ? 8'hD5 : 8'hFF) : QUIET_SM;
            bus_u.frame(8'h3C, 8'h3C, so, ro);
            bus_u.frame(8'h3C, 8'h3C, so, ro);
            check(so, qt, "send quiet");
            check(ro, qt, "recv quiet");
        end
        av_xfer(1'b1, OFS_CTRL, 32'h0);
    endtask : t_mute
    // one microport byte, eight slow clocks
    task automatic up_byte(input logic [7:0] b, input logic sel,
        input logic shr);
        sel_n <= ~sel;
        wait_m(10);
        for (int i = 7; i >= 0; i--)
        begin
            if (shr)
                host_d <= b[i];
            else
                urx <= b[i];
            wait_m(10);
            uclk <= 1'b1;
            wait_m(10);
            uclk <= 1'b0;
            if (i == 4 && sel)
                check(bd_oe, {~shr}, "bidir drive mid");
        end
        wait_m(20);
    endtask : up_byte
    // split and shared microport, select gating
    task automatic t_up();
        up_byte(8'h5A, 1'b1, 1'b0);
        check(bd_oe, 1'b1, "split drives");
        // eight falls shift the whole status byte; its last bit is strobed
        check(bd_o, 1'b1, "split status last bit");
        sel_n <= 1'b1;
        wait_m(20);
        check(bd_oe, 1'b0, "released");
        up_byte(8'h3C, 1'b0, 1'b0);
        av_xfer(1'b0, OFS_UP, 32'h0);
        check(q, 32'h5A, "split byte");
        av_xfer(1'b1, OFS_CTRL, 32'h04);
        urx <= 1'b1;
        up_byte(8'h66, 1'b1, 1'b1);
        check(bd_oe, 1'b1, "shared answers");
        sel_n <= 1'b1;
        wait_m(20);
        av_xfer(1'b0, OFS_UP, 32'h0);
        check(q, 32'h66, "shared byte");
        av_xfer(1'b1, OFS_CTRL, 32'h0);
    endtask : t_up
    // standby pin: flag, control locked, ports silent
    task automatic t_standby();
        rst_n <= 1'b0;
        wait_m(20);
        av_xfer(1'b0, OFS_STAT, 32'h0);
        check(q[1], 1'b1, "standby flag");
        av_xfer(1'b1, OFS_CTRL, 32'h08);
        av_xfer(1'b0, OFS_CTRL, 32'h0);
        check(q, 32'h0, "ctrl locked");
        bus_u.frame(8'hA7, 8'h5C, so, ro);
        check({so, ro}, 16'h0, "silent ports");
        rst_n <= 1'b1;
        wait_m(20);
        av_xfer(1'b0, OFS_STAT, 32'h0);
        check(q[1], 1'b0, "standby left");
    endtask : t_standby
    // main sequence
    initial
    begin
        {avs_read, avs_write, law, fmt, uclk, urx, host_d} = 7'h00;
        {rst, rst_n, sel_n} = 3'b111;
        avs_be = 4'hF;
        avs_addr = 5'h00;
        avs_wdata = 32'h0;
        err_count = 0;
        num_checks = 0;
        wait_m(5);
        rst <= 1'b0;
        wait_m(8);
        t_reset();
        t_strobed();
        t_pins();
        t_pass();
        t_mute();
        t_up();
        t_standby();
        stop_test();
    end
endmodule : pcm_port_pin_interface_test
